/* File: rtl/svwr_pkg.sv */
// Shared constants and types for the supervisor watchdog reset block.
// Assumes one 100 MHz clock and a classic Wishbone register bus.
// Behaviour
// - Reset holds 200 ms after recovery or watchdog.
// - Toggle stuck one level for period trips reset.
// - Toggle input decoded as high, low, floating.
// - Floating toggle input disables the watchdog.
// - Watchdog timer cleared while reset asserted.
// - Reset asserted on low supply or timeout.
// - Active-high reset is inverse of active-low.
// - Power-fail flag low when sense below reference.
// - Main supply selected when above backup or above threshold.
// - Dip during hold restarts full hold interval.
// - Watchdog restarts from zero after reset release.
// - Backup supply forces power-fail flag low.
`default_nettype none
package svwr_pkg;
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned MS_PER_S      = 1000;
   // Hold and watchdog times in ms, as printed
   localparam int unsigned RESET_HOLD_MS = 200;
   localparam int unsigned WD_PERIOD_MS  = 1600;
   localparam int unsigned TOGGLE_MIN_NS = 50;
   // Prescaler terminal: one tick per millisecond
   localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
   localparam logic [16:0] PRESC_RST     = 17'(MS_CYCLES - 1);
   localparam logic [11:0] HOLD_RST      = 12'(RESET_HOLD_MS);
   localparam logic [11:0] WDP_RST       = 12'(WD_PERIOD_MS);

   // Wishbone byte offsets
   localparam logic [3:0] ADDR_STATUS  = 4'h0;
   localparam logic [3:0] ADDR_IRQ     = 4'h4;
   localparam logic [3:0] ADDR_MASK    = 4'h8;
   localparam logic [3:0] ADDR_TIMING  = 4'hc;

   // Status / interrupt bit positions
   localparam int unsigned BIT_LOWSUP  = 0;
   localparam int unsigned BIT_WDTRIP  = 1;
   localparam int unsigned BIT_PFAIL   = 2;
   localparam int unsigned BIT_BACKUP  = 3;
   localparam int unsigned NUM_EV      = 4;

   typedef enum logic [1:0] {
      SVWR_TGL_LOW   = 2'b00,
      SVWR_TGL_HIGH  = 2'b01,
      SVWR_TGL_FLOAT = 2'b10
   } svwr_tgl_t;

   typedef enum logic [1:0] {
      SVWR_RUN   = 2'b00,
      SVWR_LOW   = 2'b01,
      SVWR_HOLD  = 2'b10
   } svwr_state_t;

   typedef struct packed {
      logic below_thr;
      logic main_gt_backup;
      logic pf_below_ref;
   } svwr_cmp_t;
endpackage : svwr_pkg
`default_nettype wire

/* File: rtl/svwr_sync.sv */
// Two-flop synchroniser bank for comparator and toggle levels.
// Assumes levels that change slowly against the clock.
`default_nettype none
module svwr_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      if (srst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : svwr_sync
`default_nettype wire

/* File: rtl/svwr_presc.sv */
// Millisecond tick prescaler with a loadable terminal count.
// Assumes the terminal comes from a software register.
`default_nettype none
module svwr_presc (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [16:0] terminal,
   output var  logic        tick
);
   logic [16:0] cnt;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else if (cnt >= terminal) begin
         cnt  <= '0;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + 17'h00001;
         tick <= 1'b0;
      end
   end
endmodule : svwr_presc
`default_nettype wire

/* File: rtl/svwr_top.sv */
// Supervisor: reset hold, three-level watchdog, power-fail, supply select.
// Assumes comparator results arrive as digital levels; toggle input
// arrives as a level plus a driven flag; Wishbone classic slave.
`default_nettype none
module svwr_top (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        supply_below_thr,
   input  wire logic        main_gt_backup,
   input  wire logic        powerfail_sense_in,
   input  wire logic        watchdog_toggle_in,
   input  wire logic        watchdog_toggle_driven,
   output var  logic        reset_out_n,
   output var  logic        reset_out,
   output var  logic        powerfail_flag_out,
   output var  logic        switched_supply_out,
   output var  logic        irq,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o
);
   svwr_pkg::svwr_cmp_t   cmp_raw;
   svwr_pkg::svwr_cmp_t   cmp;
   logic [1:0]            tgl_raw;
   logic [1:0]            tgl_s;
   svwr_pkg::svwr_tgl_t   tgl;
   svwr_pkg::svwr_tgl_t   tgl_prev;
   svwr_pkg::svwr_state_t state;
   svwr_pkg::svwr_state_t next_state;
   logic                  ms_tick;
   logic [16:0]           presc_term;
   logic [11:0]           hold_term;
   logic [11:0]           wd_term;
   logic [11:0]           hold_cnt;
   logic [11:0]           wd_cnt;
   logic                  wd_trip;
   logic                  backup_sel;
   logic                  pf_flag;
   logic [3:0]            ev_now;
   logic [3:0]            ev_prev;
   logic [3:0]            ev_rise;
   logic [3:0]            irq_stat;
   logic [3:0]            irq_mask;
   logic                  wb_req;
   logic                  wr_irq;
   logic                  wr_mask;
   logic                  wr_timing;
   logic [31:0]           rd_mux;
   logic [31:0]           status_word;

   assign cmp_raw.below_thr      = supply_below_thr;
   assign cmp_raw.main_gt_backup = main_gt_backup;
   assign cmp_raw.pf_below_ref   = ~powerfail_sense_in;
   assign tgl_raw = {watchdog_toggle_driven, watchdog_toggle_in};

   svwr_sync #(.W(3)) u_sync_cmp (
      .clk  (clk),
      .srst (srst),
      .d    (cmp_raw),
      .q    (cmp)
   );

   svwr_sync #(.W(2)) u_sync_tgl (
      .clk  (clk),
      .srst (srst),
      .d    (tgl_raw),
      .q    (tgl_s)
   );

   svwr_presc u_presc (
      .clk      (clk),
      .srst     (srst),
      .terminal (presc_term),
      .tick     (ms_tick)
   );

   assign tgl = !tgl_s[1] ? svwr_pkg::SVWR_TGL_FLOAT :
                tgl_s[0]  ? svwr_pkg::SVWR_TGL_HIGH :
                            svwr_pkg::SVWR_TGL_LOW;

   assign backup_sel = cmp.below_thr & ~cmp.main_gt_backup;

   assign wd_trip = (wd_cnt >= wd_term) & ms_tick;

   always_comb begin
      next_state = state;
      case (state)
         svwr_pkg::SVWR_LOW: begin
            if (!cmp.below_thr) next_state = svwr_pkg::SVWR_HOLD;
         end
         svwr_pkg::SVWR_HOLD: begin
            if (cmp.below_thr) next_state = svwr_pkg::SVWR_LOW;
            else if (ms_tick && hold_cnt >= hold_term - 12'h001)
               next_state = svwr_pkg::SVWR_RUN;
         end
         default: begin
            if (cmp.below_thr) next_state = svwr_pkg::SVWR_LOW;
            else if (wd_trip) next_state = svwr_pkg::SVWR_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) state <= svwr_pkg::SVWR_LOW;
      else state <= next_state;
   end

   always_ff @(posedge clk) begin
      if (srst || state != svwr_pkg::SVWR_HOLD) hold_cnt <= '0;
      else if (ms_tick) hold_cnt <= hold_cnt + 12'h001;
   end

   always_ff @(posedge clk) begin
      if (srst) tgl_prev <= svwr_pkg::SVWR_TGL_FLOAT;
      else tgl_prev <= tgl;
   end

   always_ff @(posedge clk) begin
      if (srst || state != svwr_pkg::SVWR_RUN ||
          tgl == svwr_pkg::SVWR_TGL_FLOAT || tgl != tgl_prev)
         wd_cnt <= '0;
      else if (ms_tick && wd_cnt < wd_term)
         wd_cnt <= wd_cnt + 12'h001;
   end

   assign pf_flag = ~cmp.pf_below_ref & ~backup_sel;

   always_ff @(posedge clk) begin
      if (srst) begin
         reset_out_n         <= 1'b0;
         reset_out           <= 1'b1;
         powerfail_flag_out  <= 1'b0;
         switched_supply_out <= 1'b0;
      end else begin
         reset_out_n         <= next_state == svwr_pkg::SVWR_RUN;
         reset_out           <= next_state != svwr_pkg::SVWR_RUN;
         powerfail_flag_out  <= pf_flag;
         switched_supply_out <= backup_sel;
      end
   end

   // Interrupt events
   assign ev_now = {backup_sel, ~pf_flag, 1'b0, cmp.below_thr};
   assign ev_rise = (ev_now & ~ev_prev) |
                    (wd_trip && state == svwr_pkg::SVWR_RUN ? 4'h2 : 4'h0);

   // Wishbone decode
   assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_irq    = wb_req & wb_we_i & wb_sel_i[0] &
                      (wb_adr_i == svwr_pkg::ADDR_IRQ);
   assign wr_mask   = wb_req & wb_we_i & wb_sel_i[0] &
                      (wb_adr_i == svwr_pkg::ADDR_MASK);
   assign wr_timing = wb_req & wb_we_i & (wb_adr_i == svwr_pkg::ADDR_TIMING);
   assign status_word = {26'h0, state, ev_now};

   always_comb begin
      if (wb_adr_i == svwr_pkg::ADDR_STATUS) rd_mux = status_word;
      else if (wb_adr_i == svwr_pkg::ADDR_IRQ) rd_mux = {28'h0, irq_stat};
      else if (wb_adr_i == svwr_pkg::ADDR_MASK) rd_mux = {28'h0, irq_mask};
      else if (wb_adr_i == svwr_pkg::ADDR_TIMING)
         rd_mux = {3'h0, presc_term, hold_term[11:0]};
      else rd_mux = 32'h0;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ev_prev  <= '0;
         irq_stat <= '0;
         irq_mask <= '0;
         irq      <= 1'b0;
      end else begin
         ev_prev  <= ev_now;
         // Set wins over write-one clear
         irq_stat <= (irq_stat & ~(wr_irq ? wb_dat_i[3:0] : 4'h0)) | ev_rise;
         if (wr_mask) irq_mask <= wb_dat_i[3:0];
         irq      <= |(irq_stat & irq_mask);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         presc_term <= svwr_pkg::PRESC_RST;
         hold_term  <= svwr_pkg::HOLD_RST;
         wd_term    <= svwr_pkg::WDP_RST;
      end else if (wr_timing) begin
         if (wb_sel_i[1] && wb_sel_i[0]) hold_term <= wb_dat_i[11:0];
         if (wb_sel_i[3] && wb_sel_i[2]) presc_term <= wb_dat_i[28:12];
      end else if (wb_req && wb_we_i && wb_adr_i == svwr_pkg::ADDR_STATUS &&
                   wb_sel_i[1] && wb_sel_i[0]) begin
         wd_term <= wb_dat_i[11:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_mux : 32'h0;
      end
   end
endmodule : svwr_top
`default_nettype wire

/* File: tb/svwr_monitor.sv */
// Port checker for the supervisor block.
// Bound into svwr_top; one clock, synchronous reset.
`default_nettype none
module svwr_monitor (
   input wire logic clk,
   input wire logic srst,
   input wire logic supply_below_thr,
   input wire logic main_gt_backup,
   input wire logic powerfail_sense_in,
   input wire logic watchdog_toggle_driven,
   input wire logic reset_out_n,
   input wire logic reset_out,
   input wire logic powerfail_flag_out,
   input wire logic switched_supply_out,
   input wire logic irq,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   inv_rst_a: assert property (reset_out == !reset_out_n)
      else $error("reset outputs not inverse");
   low_sup_a: assert property (supply_below_thr [*4] |=> !reset_out_n)
      else $error("reset missing on low supply");
   rel_ok_a: assert property ($rose(reset_out_n) |->
      !$past(supply_below_thr, 3)) else $error("release while supply low");
   pf_low_a: assert property
      (!powerfail_sense_in [*4] |=> !powerfail_flag_out)
      else $error("power fail flag high");
   pf_bak_a: assert property
      (switched_supply_out [*2] |-> !powerfail_flag_out)
      else $error("flag high in backup");
   sel_main_a: assert property
      ((!supply_below_thr && main_gt_backup) [*4] |=> !switched_supply_out)
      else $error("backup chosen wrongly");
   sel_bak_a: assert property
      ((supply_below_thr && !main_gt_backup) [*4] |=> switched_supply_out)
      else $error("main chosen wrongly");
   float_trip_a: assert property
      ((!watchdog_toggle_driven && !supply_below_thr) [*8]
       |-> !$fell(reset_out_n)) else $error("trip while floating");
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack late");
   ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack too long");
   cover property ($fell(reset_out_n) && !supply_below_thr);
   cover property (switched_supply_out);
   cover property ($rose(irq));
endmodule : svwr_monitor
bind svwr_top svwr_monitor mon (
   .clk                    (clk),
   .srst                   (srst),
   .supply_below_thr       (supply_below_thr),
   .main_gt_backup         (main_gt_backup),
   .powerfail_sense_in     (powerfail_sense_in),
   .watchdog_toggle_driven (watchdog_toggle_driven),
   .reset_out_n            (reset_out_n),
   .reset_out              (reset_out),
   .powerfail_flag_out     (powerfail_flag_out),
   .switched_supply_out    (switched_supply_out),
   .irq                    (irq),
   .wb_cyc_i               (wb_cyc_i),
   .wb_stb_i               (wb_stb_i),
   .wb_ack_o               (wb_ack_o)
);
`default_nettype wire

/* File: tb/svwr_host.sv */
// Host model driving the watchdog toggle pin.
// Mode 0 toggles, 1 holds, 2 floats the pin.
`default_nettype none
module svwr_host (
   input  wire logic       clk,
   input  wire logic [1:0] mode,
   input  wire logic [7:0] half,
   output var  logic       tgl,
   output var  logic       drv
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt = 8'h00;
   initial tgl = 1'b0;
   initial drv = 1'b0;
   always @(posedge clk) begin
      drv <= (mode != 2'h2);
      cnt <= cnt + 8'h01;
      if (mode == 2'h2) begin
         if (drv) tgl <= !tgl;
      end else if (mode == 2'h0 && cnt >= half) begin
         cnt <= 8'h00;
         tgl <= !tgl;
      end
   end
endmodule : svwr_host
`default_nettype wire

/* File: tb/svwr_top_tb.sv */
// Self-checking bench for svwr_top with the host model.
// Prescaler shortened to 10 cycles per ms by register.
`default_nettype none
module svwr_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD_MS = 5;
   localparam int WDP_MS  = 20;
   localparam int PT      = 9;
   logic clk = 0, srst = 1, sup = 1, mgb = 1, pfs = 1;
   logic cyc = 0, stb = 0, we = 0, ack, rst_n, rst, pf, sw, irq;
   logic tgl, drv;
   logic [1:0] mode = 2'h2;
   logic [7:0] half = 8'd40;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 0, rdat, q, seed = 32'h1b43;
   int errors = 0, n_tests = 0, n, i, nfall = 0, f0;
   logic prev_n = 0;
   always #5 clk = !clk;
   svwr_host host (.clk(clk), .mode(mode), .half(half), .tgl(tgl),
      .drv(drv));
   svwr_top dut (.clk(clk), .srst(srst), .supply_below_thr(sup),
      .main_gt_backup(mgb), .powerfail_sense_in(pfs),
      .watchdog_toggle_in(tgl), .watchdog_toggle_driven(drv),
      .reset_out_n(rst_n), .reset_out(rst), .powerfail_flag_out(pf),
      .switched_supply_out(sw), .irq(irq), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack));
   always @(posedge clk) begin
      prev_n <= rst_n;
      if (prev_n === 1'b1 && rst_n === 1'b0) nfall <= nfall + 1;
   end
   function automatic int ms_cyc(int ms);
      return ms * (PT + 1);
   endfunction : ms_cyc
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_rng(string nm, int ms, int slack, int g);
      int lo;
      int hi;
      lo = ms_cyc(ms - 1) - slack;
      hi = ms_cyc(ms + 1) + 6;
      n_tests++;
      if (g < lo || g > hi) begin
         errors++;
         $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask : chk_rng
   task automatic wb(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] s);
      int k;
      k = 0;
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= s;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = rdat;
      chk("wb_ack", 32'h1, {31'h0, ack});
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge clk);
   endtask : wb
   task automatic wait_rst(logic v, int lim);
      n = 0;
      while (rst_n !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk("rst_wait", {31'h0, v}, {31'h0, rst_n});
   endtask : wait_rst
   task automatic finish_test;
      if (errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      #300us;
      errors++;
      finish_test;
   end
   initial begin
      repeat (3) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      wb(1, 4'hc, {3'h0, 17'(PT), 12'(HOLD_MS)}, 4'hf);
      wb(1, 4'h0, 32'(WDP_MS), 4'h3);
      wb(1, 4'h8, 32'hf, 4'hf);
      wb(0, 4'h8, 0, 4'hf);
      chk("mask", 32'hf, q);
      wb(0, 4'hc, 0, 4'hf);
      chk("timing", {3'h0, 17'(PT), 12'(HOLD_MS)}, q);
      wb(0, 4'h6, 0, 4'hf);
      chk("unmapped", 0, q);
      sup <= 0;
      wait_rst(1, 300);
      chk_rng("hold", HOLD_MS, 0, n);
      repeat (20) @(posedge clk);
      sup <= 1;
      repeat (5) @(posedge clk);
      chk("dip", 0, rst_n);
      sup <= 0;
      repeat (20) @(posedge clk);
      chk("mid_hold", 0, rst_n);
      sup <= 1;
      repeat (5) @(posedge clk);
      sup <= 0;
      wait_rst(1, 300);
      chk_rng("redo", HOLD_MS, 0, n);
      wb(1, 4'h4, 32'hf, 4'hf);
      wb(0, 4'h4, 0, 4'hf);
      chk("clr", 0, q);
      chk("irq_off", 0, irq);
      mode <= 2'h1;
      wait_rst(0, 400);
      chk_rng("trip", WDP_MS, 0, n);
      wb(0, 4'h4, 0, 4'hf);
      chk("wd_bit", 32'h1 << svwr_pkg::BIT_WDTRIP, q);
      chk("irq_on", 1, irq);
      wait_rst(1, 300);
      chk_rng("wd_hold", HOLD_MS, 4, n);
      wait_rst(0, 400);
      chk_rng("again", WDP_MS, 0, n);
      wait_rst(1, 300);
      mode <= 2'h0;
      f0 = nfall;
      for (i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         half <= 8'(20 + seed[6:0] % 100);
         repeat (150) @(posedge clk);
      end
      chk("toggling", f0, nfall);
      mode <= 2'h2;
      repeat (500) @(posedge clk);
      chk("float", f0, nfall);
      for (i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         pfs <= seed[0];
         repeat (5) @(posedge clk);
         chk("pf", {31'h0, pfs}, {31'h0, pf});
      end
      pfs <= 1;
      wb(1, 4'h8, 0, 4'hf);
      wb(1, 4'h4, 32'hf, 4'hf);
      mgb <= 0;
      sup <= 1;
      repeat (6) @(posedge clk);
      chk("backup", 1, sw);
      chk("pf_bak", 0, pf);
      chk("rst_bak", 1, rst);
      chk("irq_mask", 0, irq);
      wb(1, 4'h8, 32'hf, 4'hf);
      repeat (2) @(posedge clk);
      chk("irq_unm", 1, irq);
      finish_test;
   end
endmodule : svwr_top_tb
`default_nettype wire
